// ### common/bms_defs.vh
// Constants for the boot mode select and readback block.
`ifndef BMS_DEFS_VH
`define BMS_DEFS_VH
// Board variants.
`define BMS_VAR_JUMPER 2'd0
`define BMS_VAR_MID 2'd1
`define BMS_VAR_WIDE 2'd2
// Register byte offsets.
`define BMS_OFF_READBACK 12'h008
`define BMS_OFF_STATUS 12'h010
`define BMS_OFF_CONTROL 12'h014
// Boot codes, older family numbering.
`define BMS_BM1 4'h1
`define BMS_BM3 4'h3
`define BMS_BM5 4'h5
`define BMS_BM6 4'h6
`define BMS_BM7 4'h7
`define BMS_BM9 4'h9
`define BMS_BM11 4'hb
`define BMS_BM13 4'hd
`define BMS_BM_RESERVED 4'hf
// Native wide-core codes.
`define BMS_NAT_NONE 2'd0
`define BMS_NAT_HOST 2'd1
`define BMS_NAT_FLASH 2'd2
// Copy lengths in bytes and addresses.
`define BMS_COPY_WIDE 17'h0_0400
`define BMS_COPY_OLD 17'h1_0000
`define BMS_ADDR_ZERO 32'h0000_0000
`define BMS_ADDR_INTERNAL_LOW_MEMORY_MAP_EXT 32'h0040_0000
// Boot kinds.
`define BMS_KIND_NONE 2'd0
`define BMS_KIND_HOST 2'd1
`define BMS_KIND_FLASH 2'd2
// Status register field positions.
`define BMS_ST_DONE 0
`define BMS_ST_BUSY 1
`define BMS_ST_INTERNAL_LOW_MEMORY_MAP 2
`define BMS_ST_SYNC 3
`define BMS_ST_RSVD 4
`endif

// ### verilog/bms_decode.v
// Decoder from jumper or switch settings to boot code, native code and memory plan.
`timescale 1ns/1ps
`include "bms_defs.vh"
module bms_decode
(
  // Settings; bit n-1 is jumper or switch n, 1 means ON.
  input wire [1:0] variant,
  input wire [3:0] setting,
  // Decoded results.
  output reg [3:0] code,
  output reg [1:0] native,
  output reg [1:0] kind,
  output reg internal_low_memory_map,
  output reg sync_mem,
  output reg reserved
);
  always @*
  begin
    code = `BMS_BM_RESERVED;
    native = `BMS_NAT_NONE;
    reserved = 1'b0;
    if (variant == `BMS_VAR_WIDE)
    begin
      // Switch 1 is bit 0, switch 2 is bit 1.
      case (setting[1:0])
        2'b11:
        begin
          code = `BMS_BM5;
          native = `BMS_NAT_NONE;
        end
        2'b10:
        begin
          code = `BMS_BM7;
          native = `BMS_NAT_HOST;
        end
        2'b01:
        begin
          code = `BMS_BM13;
          native = `BMS_NAT_FLASH;
        end
        default:
          reserved = 1'b1;
      endcase
    end
    else
    begin
      // Order 4,3,2,1 read ON=1; a fitted jumper reads ON.
      case (setting)
        4'b1100: code = `BMS_BM3;
        4'b1001: code = `BMS_BM6;
        4'b0100: code = `BMS_BM11;
        4'b1010: code = `BMS_BM5;
        4'b1000: code = `BMS_BM7;
        4'b0010: code = `BMS_BM13;
        4'b0110:
        begin
          if (variant == `BMS_VAR_MID)
            code = `BMS_BM9;
          else
            reserved = 1'b1;
        end
        default:
          reserved = 1'b1;
      endcase
    end
    case (code)
      `BMS_BM6, `BMS_BM7: kind = `BMS_KIND_HOST;
      `BMS_BM9, `BMS_BM11, `BMS_BM13: kind = `BMS_KIND_FLASH;
      default: kind = `BMS_KIND_NONE;
    endcase
    internal_low_memory_map = (code == `BMS_BM5) || (code == `BMS_BM7) || (code == `BMS_BM13);
    // Host-boot and map-one modes keep asynchronous timing everywhere.
    sync_mem = (code == `BMS_BM3) || (code == `BMS_BM9) || (code == `BMS_BM11);
    // The wide core has one memory map: no map-one base and no synchronous auto-select.
    if (variant == `BMS_VAR_WIDE)
    begin
      internal_low_memory_map = 1'b0;
      sync_mem = 1'b0;
    end
  end
endmodule

// ### verilog/bms_boot_ctrl.v
// Boot mode capture, readback register and boot copy sequencer.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "bms_defs.vh"
module bms_boot_ctrl
#(
  parameter [1:0] VARIANT = `BMS_VAR_MID,
  parameter ADDR_W = 17
)
(
  // Clock and on-board reset.
  input wire pclk,
  input wire presetn,
  // Board settings; 1 means ON or fitted.
  input wire [3:0] boot_setting,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Flash copy engine request.
  output reg copy_req,
  output reg [ADDR_W-1:0] copy_addr,
  input wire copy_ack,
  // Processor start and memory plan.
  output reg cpu_run,
  output reg [31:0] cpu_start_addr,
  output reg [31:0] ext_base_addr,
  output reg sync_mem_sel,
  output reg [1:0] native_code
);
  // ****************************************************************
  // Setting synchroniser and decode
  // ****************************************************************
  wire [3:0] set_sync;
  wire [3:0] dec_code;
  wire [1:0] dec_native;
  wire [1:0] dec_kind;
  wire dec_internal_low_memory_map;
  wire dec_sync;
  wire dec_rsvd;

  // Each jumper or switch is an independent asynchronous level, so every bit gets its
  // own two-stage synchroniser; only the second stage is ever read.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      reg meta;
      reg settled;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta <= 1'b0;
          settled <= 1'b0;
        end
        else
        begin
          meta <= boot_setting[gi];
          settled <= meta;
        end
      end
      assign set_sync[gi] = settled;
    end
  endgenerate

  bms_decode u_decode
  (
    .variant(VARIANT),
    .setting(set_sync),
    .code(dec_code),
    .native(dec_native),
    .kind(dec_kind),
    .internal_low_memory_map(dec_internal_low_memory_map),
    .sync_mem(dec_sync),
    .reserved(dec_rsvd)
  );

  // ****************************************************************
  // Capture and boot sequencer
  // ****************************************************************
  localparam [2:0] ST_SYNC = 3'd0;
  localparam [2:0] ST_LATCH = 3'd1;
  localparam [2:0] ST_COPY = 3'd2;
  localparam [2:0] ST_HOST = 3'd3;
  localparam [2:0] ST_RUN = 3'd4;
  localparam [2:0] ST_HALT = 3'd5;

  // Copy length depends on the variant; the wide core only fetches 1 Kbyte.
  localparam [ADDR_W-1:0] COPY_LEN =
    (VARIANT == `BMS_VAR_WIDE) ? `BMS_COPY_WIDE : `BMS_COPY_OLD;

  reg [2:0] state;
  reg [1:0] wait_cnt;
  reg [3:0] boot_code;
  reg [1:0] boot_kind;
  reg boot_internal_low_memory_map;
  reg boot_rsvd;
  reg host_done;
  reg [ADDR_W-1:0] next_copy_addr;

  always @*
  begin
    next_copy_addr = copy_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_SYNC;
      wait_cnt <= 2'd0;
      boot_code <= `BMS_BM_RESERVED;
      boot_kind <= `BMS_KIND_NONE;
      boot_internal_low_memory_map <= 1'b0;
      boot_rsvd <= 1'b0;
      copy_req <= 1'b0;
      copy_addr <= {ADDR_W{1'b0}};
      cpu_run <= 1'b0;
      cpu_start_addr <= `BMS_ADDR_ZERO;
      ext_base_addr <= `BMS_ADDR_ZERO;
      sync_mem_sel <= 1'b0;
      native_code <= `BMS_NAT_NONE;
    end
    else
    begin
      case (state)
        ST_SYNC:
        begin
          // Let the two-stage synchroniser fill before capturing.
          wait_cnt <= wait_cnt + 2'd1;
          if (wait_cnt == 2'd2)
            state <= ST_LATCH;
        end
        ST_LATCH:
        begin
          // Captured once per reset and never updated afterwards.
          boot_code <= dec_code;
          boot_kind <= dec_kind;
          boot_internal_low_memory_map <= dec_internal_low_memory_map;
          boot_rsvd <= dec_rsvd;
          native_code <= dec_native;
          sync_mem_sel <= dec_sync;
          cpu_start_addr <= `BMS_ADDR_ZERO;
          ext_base_addr <= dec_internal_low_memory_map ? `BMS_ADDR_INTERNAL_LOW_MEMORY_MAP_EXT : `BMS_ADDR_ZERO;
          copy_addr <= {ADDR_W{1'b0}};
          // Reserved patterns never start the processor.
          if (dec_rsvd)
            state <= ST_HALT;
          else if (dec_kind == `BMS_KIND_FLASH)
          begin
            copy_req <= 1'b1;
            state <= ST_COPY;
          end
          else if (dec_kind == `BMS_KIND_HOST)
            state <= ST_HOST;
          else
            state <= ST_RUN;
        end
        ST_COPY:
        begin
          // One byte per acknowledge, from flash zero to target zero.
          // Byte steps keep the counter simple; the older family pays 64K acknowledges.
          if (copy_ack)
          begin
            copy_addr <= next_copy_addr;
            if (next_copy_addr == COPY_LEN)
            begin
              copy_req <= 1'b0;
              state <= ST_RUN;
            end
          end
        end
        ST_HOST:
        begin
          // The processor runs while the host uploads over the host port.
          cpu_run <= 1'b1;
          if (host_done)
            state <= ST_RUN;
        end
        ST_RUN:
          cpu_run <= 1'b1;
        ST_HALT:
          // A reserved pattern keeps the processor stopped until the next on-board reset;
          // software has no way out, which is the safe choice for an unknown setting.
          cpu_run <= 1'b0;
        default:
          state <= ST_HALT;
      endcase
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Readback exists only on the mid and wide variants.
  localparam HAS_READBACK = (VARIANT != `BMS_VAR_JUMPER);

  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  reg [31:0] next_prdata;
  reg next_pslverr;
  wire host_release;

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  // Packs the status word: running, copying, map one, synchronous memory, reserved.
  function [31:0] status_word;
    input rsvd;
    input sync;
    input map_one;
    input [2:0] st;
    begin
      status_word = {27'h000_0000, rsvd, sync, map_one, st == ST_COPY, st == ST_RUN};
    end
  endfunction

  // Read data and the error flag are decoded in the setup cycle and registered, so both
  // stand for exactly the access cycle.
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (setup)
    begin
      if (hit(paddr, `BMS_OFF_READBACK) && HAS_READBACK && !pwrite)
        next_prdata = {28'h000_0000, boot_code};
      else if (hit(paddr, `BMS_OFF_STATUS) && !pwrite)
        next_prdata = status_word(boot_rsvd, sync_mem_sel, boot_internal_low_memory_map, state);
      else if (hit(paddr, `BMS_OFF_CONTROL))
        next_prdata = {31'h0000_0000, host_done};
      else
        next_pslverr = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************************
  // Host-boot release
  // ****************************************************************
  // The host writes bit 0 of control once its upload is complete. Outside host boot the
  // write is taken but ignored, so a stray write cannot cut short a copy.
  assign host_release = access && pwrite && hit(paddr, `BMS_OFF_CONTROL) && pwdata[0]
    && (boot_kind == `BMS_KIND_HOST);

  // The release flag is sticky until the next on-board reset.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      host_done <= 1'b0;
    else if (host_release)
      host_done <= 1'b1;
  end
endmodule

// ### testbench/bms_boot_ctrl_props.sv
// Port checker for the boot controller.
`timescale 1ns/1ps
module bms_boot_ctrl_props
#(
  parameter [1:0] VARIANT = 2'd1,
  parameter ADDR_W = 17
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Copy and start.
  input wire logic copy_req,
  input wire logic [ADDR_W-1:0] copy_addr,
  input wire logic copy_ack,
  input wire logic cpu_run,
  input wire logic [31:0] cpu_start_addr,
  input wire logic sync_mem_sel,
  input wire logic [1:0] native_code
);
  localparam int LAST = (VARIANT == 2'd2) ? 1023 : 65535;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ack_step:
    assert property (copy_req && copy_ack && copy_addr != LAST
      |=> copy_req && copy_addr == $past(copy_addr) + 1'b1) else $error("copy step wrong");
  a_last_ack:
    assert property (copy_req && copy_ack && copy_addr == LAST
      |=> !copy_req ##[0:2] cpu_run) else $error("copy end wrong");
  a_copy_hold:
    assert property (copy_req && !copy_ack |=> $stable(copy_addr)) else $error("copy moved");
  a_no_run_copy:
    assert property (copy_req |-> !cpu_run) else $error("run while copying");
  a_apb_ready:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("bad ready");
  a_ro_write:
    assert property (psel && !penable && pwrite && paddr == 12'h008
      |=> pslverr && prdata == 32'h0000_0000) else $error("write accepted");
  a_read_code:
    assert property (psel && penable && pready && !pwrite && paddr == 12'h008 && cpu_run
      |-> prdata == (native_code == 2'd0 ? 32'h0000_0005 : native_code == 2'd1 ?
      32'h0000_0007 : 32'h0000_000d)) else $error("readback wrong");
  a_host_async:
    assert property (cpu_run && native_code == 2'd1 |-> !sync_mem_sel) else $error("sync set");
  a_start_zero:
    assert property (cpu_run |-> cpu_start_addr == 32'h0000_0000) else $error("start nonzero");
  a_code_held:
    assert property (cpu_run |=> cpu_run && $stable(native_code)) else $error("code moved");
endmodule

// ### testbench/bms_copy_partner.sv
// Flash copy engine model answering the controller byte by byte.
`timescale 1ns/1ps
module bms_copy_partner
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Copy handshake.
  input wire logic copy_req,
  input wire logic slow,
  output logic copy_ack,
  output logic [31:0] bytes
);
  logic phase;
  // Slow mode answers every other cycle, so the request must be held.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      copy_ack <= 1'b0;
      phase <= 1'b0;
      bytes <= 32'h0000_0000;
    end
    else
    begin
      phase <= ~phase;
      copy_ack <= copy_req && (!slow || phase);
      if (copy_req && copy_ack)
        bytes <= bytes + 32'h0000_0001;
    end
  end
endmodule

// ### testbench/boot_mode_select_readback_tb.sv
// Self-checking bench for the wide-core boot controller.
`timescale 1ns/1ps
`include "bms_defs.vh"
module boot_mode_select_readback_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [3:0] boot_setting = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r, bytes, cpu_start_addr, ext_base_addr;
  logic pready, pslverr, copy_req, copy_ack, cpu_run, sync_mem_sel, er;
  logic [16:0] copy_addr;
  logic [1:0] native_code, s;
  int mismatches = 0, samples_checked = 0, n;
  integer seed = 32'hc8abcd8d;
  initial forever #2.5 pclk = ~pclk;
  bms_boot_ctrl #(.VARIANT(`BMS_VAR_WIDE), .ADDR_W(17)) uut (.pclk(pclk), .presetn(presetn),
    .boot_setting(boot_setting), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .copy_req(copy_req), .copy_addr(copy_addr), .copy_ack(copy_ack), .cpu_run(cpu_run),
    .cpu_start_addr(cpu_start_addr), .ext_base_addr(ext_base_addr),
    .sync_mem_sel(sync_mem_sel), .native_code(native_code));
  bms_copy_partner peer (.pclk(pclk), .presetn(presetn), .copy_req(copy_req), .slow(slow),
    .copy_ack(copy_ack), .bytes(bytes));
  task end_sim;
  begin
    $display("TB: checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task chk_bit(input logic got, input logic exp);
  begin
    chk_word({31'h0, got}, {31'h0, exp});
  end
  endtask
  function logic [3:0] exp_code(input logic [1:0] sw);
    case (sw)
      2'b11: return `BMS_BM5;
      2'b10: return `BMS_BM7;
      2'b01: return `BMS_BM13;
      default: return `BMS_BM_RESERVED;
    endcase
  endfunction
  // Status: bit 4 reserved pattern, bits 3..1 clear on the wide core, bit 0 running.
  function logic [31:0] exp_status(input logic [1:0] sw, input logic done);
    logic run;
    run = (sw == 2'b11) || (sw == 2'b01) || (sw == 2'b10 && done);
    return {27'h0, sw == 2'b00, 3'b000, run};
  endfunction
  // Setup edge, access edge, then hold until ready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
  begin
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20)
    begin
      mismatches++;
      end_sim;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      s = 2'd3 - i[1:0];
      r = $random(seed);
      presetn <= 1'b0;
      boot_setting <= {r[3:2], s};
      slow <= r[4];
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      n = 0;
      while (cpu_run !== 1'b1 && n < 4000)
      begin
        n++;
        @(posedge pclk);
      end
      if (s != 2'b00 && n >= 4000)
      begin
        mismatches++;
        end_sim;
      end
      chk_bit(cpu_run, s != 2'b00);
      chk_word(bytes, (s == 2'b01) ? 32'h0000_0400 : 32'h0000_0000);
      if (s != 2'b00)
        chk_word({30'h0, native_code}, {30'h0, 2'd3 - s});
      chk_word(ext_base_addr, `BMS_ADDR_ZERO);
      chk_bit(sync_mem_sel, 1'b0);
      apb(1'b0, `BMS_OFF_READBACK, 32'h0000_0000);
      chk_word(rd, {28'h0, exp_code(s)});
      chk_bit(er, 1'b0);
      apb(1'b1, `BMS_OFF_READBACK, r);
      chk_bit(er, 1'b1);
      apb(1'b0, `BMS_OFF_READBACK, 32'h0000_0000);
      chk_word(rd, {28'h0, exp_code(s)});
      apb(1'b0, 12'h0fc, 32'h0000_0000);
      chk_bit(er, 1'b1);
      apb(1'b0, `BMS_OFF_STATUS, 32'h0000_0000);
      chk_word(rd, exp_status(s, 1'b0));
      apb(1'b1, `BMS_OFF_CONTROL, 32'h0000_0001);
      chk_bit(er, 1'b0);
      apb(1'b0, `BMS_OFF_CONTROL, 32'h0000_0000);
      chk_word(rd, {31'h0, s == 2'b10});
      apb(1'b0, `BMS_OFF_STATUS, 32'h0000_0000);
      chk_word(rd, exp_status(s, 1'b1));
      $display("TB: test %0d done", i);
    end
    end_sim;
  end
endmodule
bind bms_boot_ctrl bms_boot_ctrl_props #(.VARIANT(VARIANT), .ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .copy_req(copy_req),
  .copy_addr(copy_addr), .copy_ack(copy_ack), .cpu_run(cpu_run),
  .cpu_start_addr(cpu_start_addr), .sync_mem_sel(sync_mem_sel), .native_code(native_code));
